// ==== design/sshc_pkg.sv ====
// Constants, field layout, timing counts and state type for the slave board host control block.
// Assumes a 40 MHz system clock and host bus pins sampled through three-flop synchronisers.
// Behaviour
// [RULE1] Write-only select port chooses one board out of sixteen sharing it.
// [RULE2] Second write-only port holds cpu reset, interrupt handshakes and DRAM window page.
// [RULE3] Every board decodes select writes; only the selected board takes control writes.
// [RULE4] Control writes and memory cycles are ignored until selected; host selects first.
// [RULE5] Valid-address low only when A16-A23 match page switch and board-valid is set.
// [RULE6] Memory cycle needs valid-address, a read or write strobe and memory status.
// [RULE7] Board-valid loads from select comparison on trailing edge of write strobe.
// [RULE8] Control port is 8-bit write-only, loaded by the host bus alone.
// [RULE9] Control bit D7 has no function; writing it changes nothing.
// [RULE10] D6 low holds cpu and dual UART reset, high lets run; resets to 0.
// [RULE11] Rising edge on D5 sets the interrupt toward the cpu; D5 resets to 0.
// [RULE12] D4 low clears and blocks host-bound interrupt, high enables it; resets to 0.
// [RULE13] D3..D0 place the 64K host window at one of sixteen 32K steps.
// [RULE14] Page bits are inverted; host writes 1111b for DRAM address zero.
// [RULE15] Window base, inverted code times 32K, is added to the host offset.
// [RULE16] System reset asserts cpu reset and clears host interrupt until D4 goes high.
// [RULE17] With D4 high, rising edge of uart bit two raises host interrupt; D4 low clears.
// [RULE18] Host interrupt set edges while D4 is low are dropped, nothing left pending.
// [RULE19] With uart bit three high, rising edge of D5 asserts cpu interrupt; low clears.
// [RULE20] While uart bit three is low, D5 edges are dropped with nothing pending.
// [RULE21] Host memory access waits until cpu grants hold; waits forever if cpu in reset.
// [RULE22] Host loads boot code, pulses cpu reset and verifies code before running.
// [RULE23] Host refreshes DRAM until the cpu has been set up to refresh it.
// [RULE24] After eight consecutive host accesses, host cycles are held off for refresh.
// [RULE25] Board-valid clears only on system reset or a non-matching select write.
// [RULE26] Control write loads all bits together and holds until next write or reset.
package sshc_pkg;

  localparam int CLK_NS = 25;

  // Host I/O ports
  localparam logic [15:0] SELECT_PORT_ADDR = 16'hFC40;
  localparam logic [15:0] CONTROL_PORT_ADDR = 16'hFC41;

  // Control port layout, D7 is not stored
  localparam int CTRL_W = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_CPU_IRQ_BIT = 5;
  localparam int CTRL_HOST_CLR_BIT = 4;
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_PAGE_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Addressing
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int BOARD_ID_W = 4;
  localparam int PAGE_SW_W = 8;
  localparam int WINDOW_SHIFT = 15;
  localparam int DRAM_AW = 19;

  // Refresh hold-off after a burst of host accesses
  localparam logic [3:0] MAX_BURST = 4'h8;

  // Timing, counts round up since each is a least time
  localparam int DRAM_CYCLE_NS = 250;
  localparam int HOLD_OFF_NS = 1000;
  localparam int LOCKOUT_NS = 4000;
  localparam logic [7:0] DRAM_CYCLES = 8'((DRAM_CYCLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_OFF_CYCLES = 8'((HOLD_OFF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] LOCKOUT_CYCLES = 8'((LOCKOUT_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ACCESS,
    ST_END,
    ST_REFRESH
  } sshc_state_t;

endpackage

// ==== design/sshc_sync3.sv ====
// Three-flop synchroniser for a group of pins; output follows once stages two and three agree.
// Assumes each bit is sampled independently; buses must be stable around their strobes.
`timescale 1ns/10ps
module sshc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered per bit so a late settling bit cannot pass a glitch
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      sync_o <= RST_VAL;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_ff[i] == s3_ff[i])
          sync_o[i] <= s3_ff[i];
      end
    end
  end
endmodule

// ==== design/sshc_irq_latch.sv ====
// Edge-set interrupt latch held clear by a low clear input.
// Assumes trigger and clear are already in the clk_i domain.
`timescale 1ns/10ps
module sshc_irq_latch (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clear_n_i,
  input wire logic trig_i,
  output logic irq_o
);
  logic trig_ff;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      trig_ff <= 1'b0;
    else
      trig_ff <= trig_i;
  end

  // [RULE18] [RULE20] Dropped while cleared
  // The clear is a level hold, so an edge during it leaves nothing behind
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      irq_o <= 1'b0;
    else if (!clear_n_i)
      irq_o <= 1'b0;
    else if (trig_i && !trig_ff)
      irq_o <= 1'b1;
  end

  a_irq_clear_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clear_n_i |=> !irq_o) else $error("irq set while clear held"); // [RULE18]
  a_irq_edge_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clear_n_i && trig_i && !trig_ff |=> irq_o) else $error("irq edge missed"); // [RULE17]
endmodule

// ==== design/sshc_top.sv ====
// Host side control of the slave board: select port, control port, window decode and access wait.
// Assumes host bus pins are asynchronous to clk_i and the cpu hold handshake comes from the cpu.
`timescale 1ns/10ps
module sshc_top
  import sshc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic [DATA_W-1:0] host_data_i,
  input wire logic pwr_n_i,
  input wire logic pdbin_i,
  input wire logic smemr_i,
  input wire logic swo_n_i,
  input wire logic sout_i,
  input wire logic [BOARD_ID_W-1:0] board_id_i,
  input wire logic [PAGE_SW_W-1:0] page_switch_i,
  input wire logic uart_out_bit_two_i,
  input wire logic uart_out_bit_three_i,
  input wire logic cpu_hold_ack_n_i,
  output logic board_valid_n_o,
  output logic valid_address_n_o,
  output logic cpu_run_n_o,
  output logic cpu_irq_o,
  output logic host_vi_o,
  output logic host_vi_oe_n_o,
  output logic prdy_o,
  output logic prdy_oe_n_o,
  output logic cpu_hold_o,
  output logic dram_req_o,
  output logic dram_we_o,
  output logic [DRAM_AW-1:0] dram_addr_o,
  output logic [CTRL_PAGE_W-1:0] window_page_sel_n_o
);
  localparam int SYNC_W = ADDR_W + DATA_W + 5 + BOARD_ID_W + PAGE_SW_W;

  logic [SYNC_W-1:0] sync_q;
  logic [2:0] strobe_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic pwr_n_q;
  logic swo_n_q;
  logic hlda_n_q;
  logic pdbin_q;
  logic smemr_q;
  logic sout_q;
  logic op2_q;
  logic op3_q;
  logic [BOARD_ID_W-1:0] id_q;
  logic [PAGE_SW_W-1:0] page_sw_q;

  logic pwr_n_prev_ff;
  logic board_valid_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic host_irq;
  logic cpu_irq;
  sshc_state_t state_ff;
  sshc_state_t nxt_state;
  logic [7:0] timer_ff;
  logic [3:0] burst_ff;
  logic [7:0] holdoff_ff;

  logic wr_trail;
  logic sel_wr;
  logic ctrl_wr;
  logic page_hit;
  logic mem_status;
  logic mem_accept;
  logic strobe_done;
  logic [CTRL_PAGE_W-1:0] page_code;

  // Active-low strobes synchronise from their idle level
  sshc_sync3 #(.W(3), .RST_VAL(3'h7)) u_sync_low (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({pwr_n_i, swo_n_i, cpu_hold_ack_n_i}),
    .sync_o(strobe_n_q)
  );

  sshc_sync3 #(.W(SYNC_W), .RST_VAL('0)) u_sync_bus (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({host_addr_i, host_data_i, pdbin_i, smemr_i, sout_i, uart_out_bit_two_i,
            uart_out_bit_three_i, board_id_i, page_switch_i}),
    .sync_o(sync_q)
  );

  assign {pwr_n_q, swo_n_q, hlda_n_q} = strobe_n_q;
  assign {addr_q, data_q, pdbin_q, smemr_q, sout_q, op2_q, op3_q, id_q, page_sw_q} = sync_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      pwr_n_prev_ff <= 1'b1;
    else
      pwr_n_prev_ff <= pwr_n_q;
  end

  // [RULE7] Trailing write edge
  assign wr_trail = pwr_n_q && !pwr_n_prev_ff;
  // [RULE3] Select decoded on every board
  assign sel_wr = wr_trail && sout_q && (addr_q[15:0] == SELECT_PORT_ADDR);
  // [RULE3] [RULE4] Control port only when selected
  assign ctrl_wr = wr_trail && sout_q && board_valid_ff && (addr_q[15:0] == CONTROL_PORT_ADDR);

  // [RULE1] [RULE25] Board-valid from compare
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      board_valid_ff <= 1'b0;
    else if (sel_wr)
      board_valid_ff <= (data_q[BOARD_ID_W-1:0] == id_q);
  end

  // [RULE2] [RULE8] [RULE9] [RULE26] Control load
  // D7 is never stored, so the host data bit has nowhere to go
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      ctrl_ff <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_ff <= data_q[CTRL_W-1:0];
  end

  // [RULE10] [RULE16] Cpu reset follows D6
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      cpu_run_n_o <= 1'b0;
    else
      cpu_run_n_o <= ctrl_ff[CTRL_RUN_BIT];
  end

  // [RULE11] [RULE19] Cpu-bound latch
  sshc_irq_latch u_cpu_irq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_n_i(op3_q),
    .trig_i(ctrl_ff[CTRL_CPU_IRQ_BIT]),
    .irq_o(cpu_irq)
  );

  // [RULE12] [RULE16] [RULE17] Host-bound latch
  sshc_irq_latch u_host_irq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clear_n_i(ctrl_ff[CTRL_HOST_CLR_BIT]),
    .trig_i(op2_q),
    .irq_o(host_irq)
  );

  // Vectored interrupt line is open drain, pulled low while pending
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cpu_irq_o <= 1'b0;
      host_vi_o <= 1'b0;
      host_vi_oe_n_o <= 1'b1;
    end
    else
    begin
      cpu_irq_o <= cpu_irq;
      host_vi_o <= 1'b0;
      host_vi_oe_n_o <= !host_irq;
    end
  end

  // [RULE5] Valid-address decode
  assign page_hit = (addr_q[ADDR_W-1:16] == page_sw_q);

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      valid_address_n_o <= 1'b1;
      board_valid_n_o <= 1'b1;
    end
    else
    begin
      valid_address_n_o <= !(page_hit && board_valid_ff);
      board_valid_n_o <= !board_valid_ff;
    end
  end

  // [RULE6] Memory cycle qualification
  assign mem_status = !sout_q && ((smemr_q && swo_n_q && pdbin_q) || (!smemr_q && !swo_n_q && !pwr_n_q));
  assign mem_accept = !valid_address_n_o && mem_status;
  assign strobe_done = !pdbin_q && pwr_n_q;

  // [RULE13] [RULE14] Page bits taken inverted
  assign page_code = ~ctrl_ff[CTRL_PAGE_LSB +: CTRL_PAGE_W];

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      window_page_sel_n_o <= '0;
    else
      window_page_sel_n_o <= ctrl_ff[CTRL_PAGE_LSB +: CTRL_PAGE_W];
  end

  // [RULE21] [RULE24] Access sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (mem_accept)
          nxt_state = ST_HOLD;
      ST_HOLD:
        if (!hlda_n_q)
          nxt_state = ST_ACCESS;
      ST_ACCESS:
        if (timer_ff == 8'h00)
          nxt_state = ST_END;
      ST_END:
        if (strobe_done)
          nxt_state = (burst_ff == MAX_BURST) ? ST_REFRESH : ST_IDLE;
      ST_REFRESH:
        if (timer_ff == 8'h00)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      timer_ff <= 8'h00;
    else if (state_ff == ST_HOLD && nxt_state == ST_ACCESS)
      timer_ff <= DRAM_CYCLES - 8'h01;
    else if (state_ff == ST_END && nxt_state == ST_REFRESH)
      timer_ff <= LOCKOUT_CYCLES - 8'h01;
    else if (timer_ff != 8'h00)
      timer_ff <= timer_ff - 8'h01;
  end

  // [RULE24] Consecutive access count
  // A pause longer than the hold-off lets the cpu run, so the burst starts over
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      burst_ff <= 4'h0;
    else if (state_ff == ST_HOLD && nxt_state == ST_ACCESS)
      burst_ff <= burst_ff + 4'h1;
    else if (state_ff == ST_REFRESH || (state_ff == ST_IDLE && holdoff_ff == 8'h00))
      burst_ff <= 4'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      holdoff_ff <= 8'h00;
    else if (state_ff == ST_END)
      holdoff_ff <= HOLD_OFF_CYCLES;
    else if (state_ff == ST_IDLE && holdoff_ff != 8'h00)
      holdoff_ff <= holdoff_ff - 8'h01;
  end

  // [RULE21] Wait held until cpu hold
  // No timeout: a host touching memory of a cpu held in reset hangs by design
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      prdy_o <= 1'b0;
      prdy_oe_n_o <= 1'b1;
      cpu_hold_o <= 1'b0;
    end
    else
    begin
      prdy_o <= 1'b0;
      // Wait kept across the lockout end so ready cannot blip high for one cycle
      prdy_oe_n_o <= !(nxt_state == ST_HOLD || nxt_state == ST_ACCESS ||
                       (state_ff == ST_REFRESH && mem_accept));
      cpu_hold_o <= (nxt_state == ST_HOLD || nxt_state == ST_ACCESS || nxt_state == ST_END ||
                     (nxt_state == ST_IDLE && holdoff_ff > 8'h01));
    end
  end

  // [RULE15] Window base added to offset
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      dram_addr_o <= '0;
      dram_req_o <= 1'b0;
      dram_we_o <= 1'b0;
    end
    else
    begin
      dram_addr_o <= DRAM_AW'({page_code, {WINDOW_SHIFT{1'b0}}}) + DRAM_AW'(addr_q[15:0]);
      dram_req_o <= (nxt_state == ST_ACCESS);
      dram_we_o <= (nxt_state == ST_ACCESS) && !smemr_q;
    end
  end

  a_select_match_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_wr && data_q[BOARD_ID_W-1:0] == id_q |=> board_valid_ff) else $error("select not loaded"); // [RULE1]
  a_select_miss_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_wr && data_q[BOARD_ID_W-1:0] != id_q |=> !board_valid_ff) else $error("mismatch kept"); // [RULE25]
  a_ctrl_needs_select: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !board_valid_ff |=> $stable(ctrl_ff)) else $error("ctrl written unselected"); // [RULE4]
  a_valid_addr_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !valid_address_n_o |-> $past(board_valid_ff) && $past(page_hit)) else $error("bad valid addr"); // [RULE5]
  a_reset_defaults: assert property (@(posedge clk_i)
    $past(!rst_b_i) |-> !cpu_run_n_o && host_vi_oe_n_o && ctrl_ff == CTRL_RESET) else $error("reset values"); // [RULE16]
  a_run_follows_d6: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr ##1 1'b1 |=> cpu_run_n_o == ctrl_ff[CTRL_RUN_BIT]) else $error("run bit lag"); // [RULE10]
  a_wait_until_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_HOLD && hlda_n_q |=> state_ff == ST_HOLD && !prdy_oe_n_o) else $error("wait dropped"); // [RULE21]
  a_burst_lockout: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_END && strobe_done && burst_ff == MAX_BURST |=> state_ff == ST_REFRESH [*8])
    else $error("no refresh lockout"); // [RULE24]
  a_lockout_no_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_REFRESH |=> !cpu_hold_o || state_ff != ST_REFRESH) else $error("hold in lockout"); // [RULE24]
  a_lockout_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_REFRESH && mem_accept |=> !prdy_oe_n_o) else $error("ready in lockout"); // [RULE24]
  a_window_add: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_ACCESS && $stable(addr_q) && $stable(ctrl_ff) |->
      dram_addr_o[DRAM_AW-1:WINDOW_SHIFT] == 4'(page_code + {3'h0, addr_q[15]})) else $error("bad window"); // [RULE15]

  c_select_board: cover property (@(posedge clk_i) disable iff (!rst_b_i) sel_wr ##1 board_valid_ff);
  c_host_access: cover property (@(posedge clk_i) disable iff (!rst_b_i) state_ff == ST_ACCESS ##1 state_ff == ST_END);
  c_refresh: cover property (@(posedge clk_i) disable iff (!rst_b_i) state_ff == ST_REFRESH);
  c_host_vi: cover property (@(posedge clk_i) disable iff (!rst_b_i) !host_vi_oe_n_o);
endmodule

// ==== test/sshc_cpu_model.sv ====
// On-board cpu hold handshake model for the host control bench.
// Assumes hold request and run control come from the block under test on clk_i.
`timescale 1ns/10ps
module sshc_cpu_model (
  input wire logic clk_i,
  input wire logic cpu_run_n_i,
  input wire logic cpu_hold_i,
  input wire logic slow_i,
  output logic cpu_hold_ack_n_o
);
  int cnt;

  initial cpu_hold_ack_n_o = 1'b1;

  // Hold grant only
  // A cpu kept in reset never grants hold, so a host access stalls for good
  always @(posedge clk_i)
  begin
    if (!cpu_run_n_i || !cpu_hold_i)
    begin
      cnt <= 0;
      cpu_hold_ack_n_o <= 1'b1;
    end
    else if (cnt >= (slow_i ? 12 : 1))
      cpu_hold_ack_n_o <= 1'b0;
    else
      cnt <= cnt + 1;
  end
endmodule

// ==== test/s100_slave_host_control_tb.sv ====
// Self-checking bench for the slave board host control block, acting as the host.
// Assumes the cpu hold model answers hold requests; switches are fixed for the run.
`timescale 1ns/10ps
module s100_slave_host_control_tb;
  import sshc_pkg::*;
  localparam logic [3:0] BOARD_ID = 4'h9;
  localparam logic [7:0] PAGE_SW = 8'h0F;
  logic clk, rst_b, pwr_n, pdbin, smemr, swo_n, sout, uart2, uart3, ack_n, slow;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic bv_n, va_n, run_n, cirq, vi, vi_oe_n, rdy, rdy_oe_n, hold, dreq, dwe, dw;
  logic [DRAM_AW-1:0] daddr, da;
  logic [CTRL_PAGE_W-1:0] pg;
  logic [3:0] pgs [4] = '{4'hF, 4'hE, 4'hD, 4'h0};
  logic [15:0] offs [4] = '{16'h0000, 16'hFFFF, 16'h3200, 16'h7FFF};
  int bad_count, comparisons, wt, w0;

  sshc_top dut (.clk_i(clk), .rst_b_i(rst_b), .host_addr_i(addr), .host_data_i(data), .pwr_n_i(pwr_n),
    .pdbin_i(pdbin), .smemr_i(smemr), .swo_n_i(swo_n), .sout_i(sout), .board_id_i(BOARD_ID),
    .page_switch_i(PAGE_SW), .uart_out_bit_two_i(uart2), .uart_out_bit_three_i(uart3),
    .cpu_hold_ack_n_i(ack_n), .board_valid_n_o(bv_n), .valid_address_n_o(va_n), .cpu_run_n_o(run_n),
    .cpu_irq_o(cirq), .host_vi_o(vi), .host_vi_oe_n_o(vi_oe_n), .prdy_o(rdy), .prdy_oe_n_o(rdy_oe_n),
    .cpu_hold_o(hold), .dram_req_o(dreq), .dram_we_o(dwe), .dram_addr_o(daddr), .window_page_sel_n_o(pg));

  sshc_cpu_model cpu (.clk_i(clk), .cpu_run_n_i(run_n), .cpu_hold_i(hold), .slow_i(slow),
    .cpu_hold_ack_n_o(ack_n));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
    cyc(6);
  endtask

  // Setup, strobe width and hold all kept at eight cycles, above the bus minimums
  task automatic io_wr(input logic [15:0] port, input logic [7:0] val);
    @(negedge clk);
    addr = {8'h00, port};
    data = val;
    sout = 1'b1;
    swo_n = 1'b0;
    cyc(8);
    pwr_n = 1'b0;
    cyc(8);
    pwr_n = 1'b1;
    cyc(8);
    sout = 1'b0;
    swo_n = 1'b1;
    cyc(4);
  endtask

  // Wait counts cycles of ready held low; 400 means the access never ended
  task automatic mem(input logic [23:0] a, input logic we);
    int n;
    @(negedge clk);
    addr = a;
    smemr = !we;
    swo_n = !we;
    da = 'x;
    dw = 1'bx;
    wt = 0;
    n = 0;
    cyc(2);
    if (we)
      pwr_n = 1'b0;
    else
      pdbin = 1'b1;
    while (rdy_oe_n !== 1'b0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    while (rdy_oe_n === 1'b0 && wt < 400)
    begin
      if (dreq === 1'b1)
      begin
        da = daddr;
        dw = dwe;
      end
      cyc(1);
      wt++;
    end
    pwr_n = 1'b1;
    pdbin = 1'b0;
    cyc(2);
    smemr = 1'b0;
    swo_n = 1'b1;
  endtask

  initial
  begin
    {pwr_n, swo_n, uart3} = 3'h7;
    {pdbin, smemr, sout, uart2, slow} = 5'h00;
    addr = 24'h000000;
    data = 8'h00;
    do_reset();
    chk({run_n, cirq, vi_oe_n, rdy_oe_n, bv_n, pg, vi, rdy}, 11'h1C0);
    io_wr(CONTROL_PORT_ADDR, 8'h7F);
    chk({run_n, pg}, 5'h00);
    mem({PAGE_SW, 16'h0100}, 1'b1);
    chk(wt, 0);
    chk(va_n, 1);
    for (int i = 0; i < 16; i++)
    begin
      io_wr(SELECT_PORT_ADDR, {4'hA, 4'(i)});
      chk(bv_n, (4'(i) == BOARD_ID) ? 0 : 1);
    end
    io_wr(SELECT_PORT_ADDR, {4'h0, BOARD_ID});
    chk(bv_n, 0);
    io_wr(CONTROL_PORT_ADDR, 8'hCE);
    chk({run_n, vi_oe_n, pg}, 6'h3E);
    slow = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      io_wr(CONTROL_PORT_ADDR, {4'h4, pgs[j]});
      mem({PAGE_SW, offs[j]}, pgs[j][0]);
      chk(da, {pgs[j] ^ 4'hF, 15'h0000} + {3'h0, offs[j]});
      chk(dw, pgs[j][0]);
    end
    chk(va_n, 0);
    slow = 1'b0;
    mem({8'h0E, 16'h3200}, 1'b0);
    chk(wt, 0);
    chk(va_n, 1);
    cyc(100);
    // Nine host reads in a row; the ninth is held off by the refresh lockout
    for (int k = 0; k < 9; k++)
    begin
      mem({PAGE_SW, 16'h0040}, 1'b0);
      if (k == 0)
        w0 = wt;
    end
    chk({w0 < 60, wt > 60}, 2'h3);
    // Boot word written with the cpu running, reset pulsed, then read back
    io_wr(CONTROL_PORT_ADDR, 8'h40);
    mem({PAGE_SW, 16'h7FF0}, 1'b1);
    chk({dw, da}, {1'b1, 19'h7FFF0});
    io_wr(CONTROL_PORT_ADDR, 8'h00);
    chk(run_n, 0);
    io_wr(CONTROL_PORT_ADDR, 8'h40);
    mem({PAGE_SW, 16'h7FF0}, 1'b0);
    chk({dw, da}, {1'b0, 19'h7FFF0});
    io_wr(CONTROL_PORT_ADDR, 8'h4E);
    io_wr(CONTROL_PORT_ADDR, 8'h6E);
    chk(cirq, 1);
    uart3 = 1'b0;
    cyc(6);
    chk(cirq, 0);
    io_wr(CONTROL_PORT_ADDR, 8'h4E);
    io_wr(CONTROL_PORT_ADDR, 8'h6E);
    uart3 = 1'b1;
    cyc(6);
    chk(cirq, 0);
    uart2 = 1'b1;
    cyc(10);
    chk(vi_oe_n, 1);
    uart2 = 1'b0;
    io_wr(CONTROL_PORT_ADDR, 8'h5E);
    chk(vi_oe_n, 1);
    uart2 = 1'b1;
    cyc(10);
    chk(vi_oe_n, 0);
    io_wr(CONTROL_PORT_ADDR, 8'h4E);
    chk(vi_oe_n, 1);
    uart2 = 1'b0;
    io_wr(SELECT_PORT_ADDR, 8'h03);
    chk(bv_n, 1);
    io_wr(CONTROL_PORT_ADDR, 8'h0F);
    chk({run_n, pg}, 5'h1E);
    io_wr(SELECT_PORT_ADDR, {4'h0, BOARD_ID});
    io_wr(CONTROL_PORT_ADDR, 8'h0F);
    chk(run_n, 0);
    mem({PAGE_SW, 16'h0010}, 1'b1);
    chk({wt, dw}, {32'd400, 1'bx});
    chk(hold, 1);
    do_reset();
    chk({bv_n, rdy_oe_n, run_n, hold}, 4'hC);
    report_and_stop();
  end

  initial
  begin
    cyc(20000);
    bad_count++;
    report_and_stop();
  end
endmodule
